/* hdl/dac_pkg.sv */
/*
  Constants, register map and field layout of the dual action submodule.
  Assumes one clock domain (hclk) shared with the time-base buses.
*/
// What this block does
// - Mode 0000 disables the channel; 0001 measures pulse width, 16 bits.
// - Mode 0010 measures period; 0011 is plain input capture, both 16 bits.
// - Mode 0100 is output compare; only a channel B match sets the flag.
// - Mode 0101 is output compare; an A or B match sets the flag.
// - Modes 1000-1111 are PWM with 16,15,14,13,12,11,9,7 bits resolution.
// - Channel A data is a 16-bit register whose meaning follows the mode.
// - While disabled, channel A data stays readable and writable for preload.
// - In pulse-width mode channel A holds the trailing-edge time-base capture.
// - In period and capture modes channel A holds the latest selected edge.
// - In compare modes channel A holds the leading-edge compare value.
// - In compare modes a channel A write arms its comparator until a match.
// - In PWM mode channel A holds the leading-edge compare value.
// - Channel B accesses reach the first or second buffer by mode.
// - Event flag set per mode on captures and matches, held clear when disabled.
// - Polarity picks capture edges, B opposite in pulse width; output action.
// - Polarity 0: A match drives high, B low; polarity 1 reverses both.
// - B reaches first buffer in disabled/PWM, copied to second at each A match in PWM.
package dac_pkg;

  localparam logic [7:0] DAC_OFS_CTRL = 8'h00;
  localparam logic [7:0] DAC_OFS_A    = 8'h04;
  localparam logic [7:0] DAC_OFS_B    = 8'h08;
  localparam logic [7:0] DAC_OFS_STAT = 8'h0c;
  localparam logic [7:0] DAC_OFS_MASK = 8'h10;

  // Control register field positions, then the flag bit of the status and mask registers.
  localparam int DAC_POS_MODE  = 0;
  localparam int DAC_POS_EDGE_POL   = 4;
  localparam int DAC_POS_FORCE_A    = 5;
  localparam int DAC_POS_FORCE_B    = 6;
  localparam int DAC_POS_OPEN_DRAIN = 7;
  localparam int DAC_POS_BUS_SEL    = 8;
  localparam int DAC_POS_PIN   = 9;
  localparam int DAC_POS_FLAG  = 0;

  localparam logic [3:0]  DAC_MODE_OFF     = 4'h0;
  localparam logic [3:0]  DAC_MODE_PULSE   = 4'h1;
  localparam logic [3:0]  DAC_MODE_PERIOD  = 4'h2;
  localparam logic [3:0]  DAC_MODE_CAPTURE = 4'h3;
  localparam logic [3:0]  DAC_MODE_CMP_B   = 4'h4;
  localparam logic [3:0]  DAC_MODE_CMP_AB  = 4'h5;
  localparam logic [3:0]  DAC_MODE_PWM16 = 4'h8;

  localparam logic [15:0] DAC_DATA_RST = 16'h0000;
  localparam logic [31:0] DAC_RD_ZERO  = 32'h0000_0000;

  typedef struct packed {
    logic       bus_sel;
    logic       open_drain;
    logic       edge_pol;
    logic [3:0] mode;
  } dac_ctrl_type;

  localparam dac_ctrl_type DAC_CTRL_RST = '{bus_sel: 1'b0, open_drain: 1'b0, edge_pol: 1'b0,
                                            mode: 4'h0};

endpackage

/* hdl/dac_channel.sv */
/*
  Dual action capture/compare channel with an AHB-Lite register slave.
  Assumes both time-base buses run on hclk; the pin input is asynchronous.
*/
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module dac_channel
  import dac_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [15:0] tb_bus_a,
  input  wire logic [15:0] tb_bus_b,
  input  wire logic        pin_in,
  output logic             pin_out,
  output logic             pin_oe_n,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [7:0]  addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;

  // Reads take one wait state so that a write in the previous data phase
  // is always visible to the following read.
  wire addr_ok = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      rd_pend_q <= addr_ok & ~hwrite;
      if (addr_ok) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= DAC_RD_ZERO;
    end else if (rd_pend_q) begin
      hrdata_q <= rd_mux;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = ~rd_pend_q;
  assign hresp     = 1'b0;

  wire wr_ctrl = wr_pend_q & (addr_q == DAC_OFS_CTRL);
  wire wr_a    = wr_pend_q & (addr_q == DAC_OFS_A);
  wire wr_b    = wr_pend_q & (addr_q == DAC_OFS_B);
  wire wr_stat = wr_pend_q & (addr_q == DAC_OFS_STAT);
  wire wr_mask = wr_pend_q & (addr_q == DAC_OFS_MASK);

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  dac_ctrl_type ctrl_q;
  logic         mask_q;
  logic         flag_q;
  logic [15:0]  a_q;
  logic [15:0]  b_first_q;
  logic [15:0]  b_second_q;
  logic         arm_a_q;
  logic         arm_b_q;
  logic         first_q;
  logic         ff_q;
  logic [15:0]  tb_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= DAC_CTRL_RST;
      mask_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q.mode  <= hwdata[DAC_POS_MODE +: 4];
        ctrl_q.edge_pol   <= hwdata[DAC_POS_EDGE_POL];
        ctrl_q.open_drain <= hwdata[DAC_POS_OPEN_DRAIN];
        ctrl_q.bus_sel    <= hwdata[DAC_POS_BUS_SEL];
      end
      if (wr_mask) begin
        mask_q <= hwdata[DAC_POS_FLAG];
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire m_off     = (ctrl_q.mode == DAC_MODE_OFF);
  wire m_pulse   = (ctrl_q.mode == DAC_MODE_PULSE);
  wire m_period  = (ctrl_q.mode == DAC_MODE_PERIOD);
  wire m_capture = (ctrl_q.mode == DAC_MODE_CAPTURE);
  wire m_cmp_b   = (ctrl_q.mode == DAC_MODE_CMP_B);
  wire m_cmp_ab  = (ctrl_q.mode == DAC_MODE_CMP_AB);
  wire m_pwm     = ctrl_q.mode[3];
  wire m_oc      = m_cmp_b | m_cmp_ab;
  wire m_out     = m_oc | m_pwm;
  wire m_in      = m_pulse | m_period | m_capture;

  // Codes 0110 and 0111 are unused: the channel then neither captures nor
  // compares, but registers stay accessible.

  // Reduced PWM resolution drops upper time-base bits.
  logic [15:0] res_mask;
  always_comb begin
    unique case (ctrl_q.mode[2:0])
      3'h0:    res_mask = 16'hffff;
      3'h1:    res_mask = 16'h7fff;
      3'h2:    res_mask = 16'h3fff;
      3'h3:    res_mask = 16'h1fff;
      3'h4:    res_mask = 16'h0fff;
      3'h5:    res_mask = 16'h07ff;
      3'h6:    res_mask = 16'h01ff;
      default: res_mask = 16'h007f;
    endcase
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser and edge detection
  // ----------------------------------------------------------------
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  wire rise   = pin_s2_q & ~pin_s3_q;
  wire fall   = ~pin_s2_q & pin_s3_q;
  wire edge_a = ctrl_q.edge_pol ? fall : rise;
  wire edge_b = ctrl_q.edge_pol ? rise : fall;

  // ----------------------------------------------------------------
  // Time base and comparators
  // ----------------------------------------------------------------
  wire [15:0] tb     = ctrl_q.bus_sel ? tb_bus_b : tb_bus_a;
  // A slow time base holds one value for many cycles; a match acts once.
  wire        tb_new = (tb != tb_prev_q);
  wire [15:0] cmp_m  = m_pwm ? res_mask : 16'hffff;
  wire        eq_a   = ((tb & cmp_m) == (a_q & cmp_m));
  wire        eq_b   = ((tb & cmp_m) == (b_second_q & cmp_m));

  wire match_a = tb_new & eq_a & ((m_oc & arm_a_q) | m_pwm);
  wire match_b = tb_new & eq_b & ((m_oc & arm_b_q) | m_pwm);

  wire cap_pulse_lead  = m_pulse & edge_a;
  wire cap_pulse_trail = m_pulse & edge_b;
  wire cap_a           = cap_pulse_trail | ((m_period | m_capture) & edge_a);

  wire force_a = wr_ctrl & m_out & hwdata[DAC_POS_FORCE_A];
  wire force_b = wr_ctrl & m_out & hwdata[DAC_POS_FORCE_B];
  wire act_a   = match_a | force_a;
  wire act_b   = match_b | force_b;

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  wire b_to_first = m_off | m_pwm;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_q <= DAC_DATA_RST;
    end else if (cap_a) begin
      a_q <= tb;
    end else if (wr_a) begin
      a_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      b_first_q <= DAC_DATA_RST;
    end else if (cap_pulse_lead) begin
      b_first_q <= tb;
    end else if (wr_b & b_to_first) begin
      b_first_q <= hwdata[15:0];
    end
  end

  // The second buffer takes the leading-edge capture at the trailing edge
  // so that software reads a consistent pulse pair.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      b_second_q <= DAC_DATA_RST;
    end else if (cap_pulse_trail) begin
      b_second_q <= b_first_q;
    end else if ((m_period | m_capture) & edge_a) begin
      b_second_q <= a_q;
    end else if (m_pwm & match_a) begin
      b_second_q <= b_first_q;
    end else if (wr_b & ~m_pwm) begin
      b_second_q <= hwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Comparator arming and first-edge tracking
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm_a_q   <= 1'b0;
      arm_b_q   <= 1'b0;
      first_q   <= 1'b1;
      tb_prev_q <= DAC_DATA_RST;
    end else begin
      tb_prev_q <= tb;
      if (wr_ctrl) begin
        arm_a_q <= 1'b0;
        arm_b_q <= 1'b0;
        first_q <= 1'b1;
      end else begin
        if (wr_a & m_oc) begin
          arm_a_q <= 1'b1;
        end else if (match_a) begin
          arm_a_q <= 1'b0;
        end
        if (wr_b & m_oc) begin
          arm_b_q <= 1'b1;
        end else if (match_b) begin
          arm_b_q <= 1'b0;
        end
        if (m_period & edge_a) begin
          first_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flag and interrupt
  // ----------------------------------------------------------------
  logic flag_set;
  always_comb begin
    flag_set = 1'b0;
    if (m_pulse | m_capture) begin
      flag_set = cap_a;
    end else if (m_period) begin
      flag_set = edge_a & ~first_q;
    end else if (m_cmp_b) begin
      flag_set = match_b;
    end else if (m_cmp_ab) begin
      flag_set = match_a | match_b;
    end else if (m_pwm) begin
      flag_set = match_a;
    end
  end

  wire flag_clr = wr_stat & hwdata[DAC_POS_FLAG];
  // Selecting the disabled mode clears the flag at once, so irq drops with it.
  wire go_off   = wr_ctrl & (hwdata[DAC_POS_MODE +: 4] == DAC_MODE_OFF);

  // A new event wins over a status-register clear in the same cycle; disabling wins over both.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= 1'b0;
    end else if (m_off | go_off) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_set | (flag_q & ~flag_clr);
    end
  end

  assign irq = flag_q & mask_q;

  // ----------------------------------------------------------------
  // Output flip-flop and pin drive
  // ----------------------------------------------------------------
  // Both forces together reset the flip-flop, as does a simultaneous match.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ff_q <= 1'b0;
    end else if (act_b) begin
      ff_q <= 1'b0;
    end else if (act_a) begin
      ff_q <= 1'b1;
    end
  end

  wire out_lvl = ff_q ^ ctrl_q.edge_pol;

  assign pin_out  = m_out & out_lvl;
  // In open-drain operation the pin is only driven while low.
  assign pin_oe_n = ~(m_out & (~ctrl_q.open_drain | ~out_lvl));

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  wire        pin_stat = m_out ? out_lvl : pin_s2_q;
  wire [15:0] b_rd     = b_to_first ? b_first_q : b_second_q;

  always_comb begin
    rd_mux = DAC_RD_ZERO;
    unique case (addr_q)
      DAC_OFS_CTRL: begin
        rd_mux[DAC_POS_MODE +: 4]  = ctrl_q.mode;
        rd_mux[DAC_POS_EDGE_POL]   = ctrl_q.edge_pol;
        rd_mux[DAC_POS_OPEN_DRAIN] = ctrl_q.open_drain;
        rd_mux[DAC_POS_BUS_SEL]    = ctrl_q.bus_sel;
        rd_mux[DAC_POS_PIN]       = pin_stat;
      end
      DAC_OFS_A:    rd_mux[15:0]          = a_q;
      DAC_OFS_B:    rd_mux[15:0]          = b_rd;
      DAC_OFS_STAT: rd_mux[DAC_POS_FLAG]  = flag_q;
      DAC_OFS_MASK: rd_mux[DAC_POS_FLAG]  = mask_q;
      default:      rd_mux                = DAC_RD_ZERO;
    endcase
  end

  // Unused bus inputs are part of the protocol but carry no meaning here.
  wire unused_ok = &{1'b0, hsize, haddr[31:8], m_in};

endmodule

/* bench/dac_channel_properties.sv */
/*
  Concurrent checks on the ports of the dual action channel.
  Assumes one clock, hclk, and the single-slave bus where hready is hreadyout.
*/
`timescale 1ns/1ps
module dac_channel_properties
  import dac_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [15:0] tb_bus_a,
  input wire logic [15:0] tb_bus_b,
  input wire logic        pin_in,
  input wire logic        pin_out,
  input wire logic        pin_oe_n,
  input wire logic        irq
);
  logic       wph_q;
  logic [7:0] wad_q;
  logic [3:0] mode_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph_q <= 1'b0;
      wad_q <= 8'h00;
    end else if (hready) begin
      wph_q <= hsel && htrans[1] && hwrite;
      wad_q <= haddr[7:0];
    end
  end

  // Data phase of a write, seen at the edge where it completes.
  wire logic wr_ctl  = wph_q && hready && wad_q == DAC_OFS_CTRL;
  wire logic rd_take = hsel && htrans[1] && hready && !hwrite;
  wire logic oc_mode = hwdata[3:1] == 3'b010;

  // Forces act only if an output mode was already selected before the write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= 4'h0;
    end else if (wr_ctl) begin
      mode_q <= hwdata[3:0];
    end
  end

  wire logic was_out = mode_q[3] || mode_q[3:1] == 3'b010;
  wire logic oc_go   = wr_ctl && was_out && oc_mode;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved");
  a_upper_zero: assert property (rd_take |-> ##2 hrdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (rd_take && haddr[7:0] > DAC_OFS_MASK |-> ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_dis_quiet: assert property (wr_ctl && hwdata[3:0] == DAC_MODE_OFF |=> !irq && pin_oe_n && !pin_out)
    else $error("disabled channel active");
  a_input_quiet: assert property (wr_ctl && hwdata[3:2] == 2'b00 && hwdata[1:0] != 2'b00 |=> pin_oe_n)
    else $error("input mode drives pin");
  a_output_drive: assert property (wr_ctl && (hwdata[3] || oc_mode) && !hwdata[7] |=> !pin_oe_n)
    else $error("output mode not driving");
  a_force_set: assert property (oc_go && hwdata[6:4] == 3'b010 |=> pin_out)
    else $error("force A did not set output");
  a_force_both: assert property (oc_go && hwdata[6:4] == 3'b110 |=> !pin_out)
    else $error("double force did not clear");
  a_mask_off: assert property (wph_q && hready && wad_q == DAC_OFS_MASK && !hwdata[0] |=> !irq)
    else $error("masked interrupt raised");
endmodule

bind dac_channel dac_channel_properties u_dac_channel_properties (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .tb_bus_a,
  .tb_bus_b, .pin_in, .pin_out, .pin_oe_n, .irq);

/* bench/dac_far_side.sv */
/*
  Far side of the channel: the time-base counters and the channel pin.
  Assumes the bench sets the external pin level and holds counter A at preset and counter B at its inverse.
*/
`timescale 1ns/1ps
module dac_far_side
  import dac_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hold,
  input  wire logic [15:0] preset,
  input  wire logic        ext_level,
  input  wire logic        pin_out,
  input  wire logic        pin_oe_n,
  output logic      [15:0] tb_bus_a,
  output logic      [15:0] tb_bus_b,
  output logic             pin_in
);
  // An undriven pin reads the level that the bench sets on ext_level.
  assign pin_in = pin_oe_n ? ext_level : pin_out;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tb_bus_a <= 16'h0000;
      tb_bus_b <= 16'h0000;
    end else if (hold) begin
      tb_bus_a <= preset;
      tb_bus_b <= ~preset;
    end else begin
      tb_bus_a <= tb_bus_a + 16'h0001;
      tb_bus_b <= tb_bus_b - 16'h0001;
    end
  end
endmodule

/* bench/tb.sv */
/*
  Self-checking bench: register tasks on AHB-Lite, then capture, compare and PWM runs.
  Assumes the far-side model freezes time base A at preset and time base B at its inverse while hold is high.
*/
`timescale 1ns/1ps
module tb;
  import dac_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic        pin_in, pin_out, pin_oe_n, hold, ext;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] tb_bus_a, tb_bus_b, preset, msk;
  wire  logic  hready = hreadyout;
  int          err_total, checks_done;
  int          rtab[8] = '{16, 15, 14, 13, 12, 11, 9, 7};

  dac_channel u_dac_channel (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .tb_bus_a, .tb_bus_b, .pin_in, .pin_out,
    .pin_oe_n, .irq);
  dac_far_side u_dac_far_side (.hclk, .hresetn, .hold, .preset, .ext_level(ext), .pin_out,
    .pin_oe_n, .tb_bus_a, .tb_bus_b, .pin_in);

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic pin_edge(input logic [15:0] t, input logic v);
    hold   <= 1'b1;
    preset <= t;
    wt(1);
    ext <= v;
    wt(8);
  endtask
  task automatic done(input string s);
    $display("test %s finished, mismatches %0d", s, err_total);
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // The whole run is under 3000 cycles; this limit only cuts a hang.
  initial begin
    #50000;
    err_total++;
    complete_run;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    hold = 1'b1;
    preset = 16'h0;
    ext = 1'b0;
    wt(2);
    hresetn <= 1'b1;
    wt(1);
    wr(8'h14, 32'h5a5a);
    for (int i = 0; i < 6; i++) rc(8'(4 * i), 32'h0);
    done("reset");
    wr(DAC_OFS_A, 32'h1234);
    wr(DAC_OFS_B, 32'habcd);
    rc(DAC_OFS_A, 32'h1234);
    rc(DAC_OFS_B, 32'habcd);
    done("preload");
    wr(DAC_OFS_CTRL, {28'h0, DAC_MODE_CAPTURE});
    wr(DAC_OFS_MASK, 32'h1);
    pin_edge(16'h0111, 1'b1);
    rc(DAC_OFS_A, 32'h0111);
    rc(DAC_OFS_B, 32'h1234);
    chk(irq, 1);
    wr(DAC_OFS_MASK, 32'h0);
    wt(1);
    chk(irq, 0);
    wr(DAC_OFS_MASK, 32'h1);
    wr(DAC_OFS_STAT, 32'h1);
    wt(1);
    chk(irq, 0);
    rc(DAC_OFS_STAT, 32'h0);
    pin_edge(16'h0222, 1'b0);
    rc(DAC_OFS_A, 32'h0111);
    wr(DAC_OFS_CTRL, {28'h0, DAC_MODE_CAPTURE} | 32'h110);
    pin_edge(16'h0333, 1'b1);
    rc(DAC_OFS_A, 32'h0111);
    pin_edge(16'h0444, 1'b0);
    rc(DAC_OFS_A, 32'h0000_fbbb);
    rc(DAC_OFS_CTRL, 32'h0000_0113);
    wr(DAC_OFS_STAT, 32'h1);
    wr(DAC_OFS_MASK, 32'h0);
    done("capture");
    wr(DAC_OFS_CTRL, {28'h0, DAC_MODE_PERIOD});
    pin_edge(16'h0400, 1'b1);
    rc(DAC_OFS_STAT, 32'h0);
    pin_edge(16'h0450, 1'b0);
    pin_edge(16'h0500, 1'b1);
    rc(DAC_OFS_STAT, 32'h1);
    rc(DAC_OFS_B, 32'h0400);
    wr(DAC_OFS_CTRL, 32'h0);
    rc(DAC_OFS_STAT, 32'h0);
    pin_edge(16'h0, 1'b0);
    wr(DAC_OFS_CTRL, {28'h0, DAC_MODE_PULSE});
    pin_edge(16'h0300, 1'b1);
    pin_edge(16'h0345, 1'b0);
    rc(DAC_OFS_A, 32'h0345);
    rc(DAC_OFS_B, 32'h0300);
    done("measure");
    wr(DAC_OFS_STAT, 32'h1);
    wr(DAC_OFS_CTRL, {28'h0, DAC_MODE_CMP_B});
    wr(DAC_OFS_CTRL, {28'h0, DAC_MODE_CMP_B} | 32'h20);
    wt(1);
    chk(pin_out, 1);
    chk(pin_oe_n, 0);
    wr(DAC_OFS_CTRL, {28'h0, DAC_MODE_CMP_B} | 32'h60);
    preset <= 16'h1000;
    wr(DAC_OFS_A, 32'h1008);
    hold <= 1'b0;
    wt(30);
    chk(pin_out, 1);
    rc(DAC_OFS_STAT, 32'h0);
    hold <= 1'b1;
    preset <= 16'h2000;
    wr(DAC_OFS_B, 32'h2008);
    hold <= 1'b0;
    wt(30);
    chk(pin_out, 0);
    rc(DAC_OFS_STAT, 32'h1);
    pin_edge(16'h1000, 1'b0);
    hold <= 1'b0;
    wt(30);
    chk(pin_out, 0);
    wr(DAC_OFS_STAT, 32'h1);
    wr(DAC_OFS_CTRL, {28'h0, DAC_MODE_CMP_AB} | 32'h30);
    wt(1);
    chk(pin_out, 0);
    pin_edge(16'h3000, 1'b0);
    wr(DAC_OFS_B, 32'h3004);
    hold <= 1'b0;
    wt(20);
    chk(pin_out, 1);
    wr(DAC_OFS_STAT, 32'h1);
    pin_edge(16'h4000, 1'b0);
    wr(DAC_OFS_A, 32'h4004);
    hold <= 1'b0;
    wt(20);
    chk(pin_out, 0);
    rc(DAC_OFS_STAT, 32'h1);
    wr(DAC_OFS_CTRL, {28'h0, DAC_MODE_CMP_B} | 32'ha0);
    wt(1);
    chk(pin_oe_n, 1);
    wr(DAC_OFS_CTRL, {28'h0, DAC_MODE_CMP_B} | 32'hc0);
    wt(1);
    chk(pin_oe_n, 0);
    chk(pin_out, 0);
    done("compare");
    for (int m = 8; m < 16; m++) begin
      msk = 16'((32'h1 << rtab[m - 8]) - 1);
      wr(DAC_OFS_CTRL, 32'h0);
      hold <= 1'b1;
      preset <= 16'h8000 & ~msk;
      wr(DAC_OFS_A, {16'h0, ~msk | 16'h0010});
      wr(DAC_OFS_B, {16'h0, ~msk | 16'h0040});
      wr(DAC_OFS_CTRL, 32'(m));
      hold <= 1'b0;
      wt(40);
      chk(pin_out, 1);
      wt(48);
      chk(pin_out, 0);
      rc(DAC_OFS_STAT, 32'h1);
      rc(DAC_OFS_B, {16'h0, ~msk | 16'h0040});
    end
    done("pwm");
    complete_run;
  end
endmodule
